// ==== rtl/uial_pkg.sv ====
// package for the user input assertion logic block
`default_nettype none
package uial_pkg;
   // register byte offsets
   localparam logic [7:0] UIAL_OFS_CTRL   = 8'h00;
   localparam logic [7:0] UIAL_OFS_LABEL  = 8'h04;
   localparam logic [7:0] UIAL_OFS_DELAY  = 8'h08;
   localparam logic [7:0] UIAL_OFS_STATUS = 8'h0c;
   localparam logic [7:0] UIAL_OFS_EVENT  = 8'h10;
   localparam logic [7:0] UIAL_OFS_MASK   = 8'h14;
   // control field positions
   localparam int UIAL_CTRL_MODE_LSB = 0;
   localparam int UIAL_CTRL_FUNC_LSB = 4;
   localparam int UIAL_CTRL_RLY_LSB  = 8;
   localparam int UIAL_CTRL_LBL_BIT  = 12;
   localparam logic [31:0] UIAL_LABEL_DEFAULT = 32'h0000_0000;
   localparam logic [31:0] UIAL_ZERO = 32'h0000_0000;
   // relay numbering: selectable auxiliary relays 3..7
   localparam logic [2:0] UIAL_RLY_MIN = 3'h3;
   localparam logic [2:0] UIAL_RLY_MAX = 3'h7;
   localparam int UIAL_RLY_N = 5;
   // pickup delay in units of 10 ms, default 0.00 s
   localparam int UIAL_DLY_UNIT_NS = 10_000_000;
   localparam int UIAL_CLK_NS = 8;
   localparam int UIAL_DLY_UNIT_CYC = UIAL_DLY_UNIT_NS / UIAL_CLK_NS;
   localparam logic [15:0] UIAL_DLY_RESET = 16'h0000;
   // interrupt event bits
   localparam int UIAL_EV_ASSERT = 0;
   localparam int UIAL_EV_CLEAR  = 1;

   typedef enum logic [3:0] {
      UIAL_M_CLOSED     = 4'h0,
      UIAL_M_OPEN       = 4'h1,
      UIAL_M_VON        = 4'h2,
      UIAL_M_VOFF       = 4'h3,
      UIAL_M_CL_AND_VON = 4'h4,
      UIAL_M_CL_AND_VOF = 4'h5,
      UIAL_M_OP_AND_VON = 4'h6,
      UIAL_M_OP_AND_VOF = 4'h7,
      UIAL_M_CL_OR_VON  = 4'h8,
      UIAL_M_CL_OR_VOF  = 4'h9,
      UIAL_M_OP_OR_VON  = 4'ha,
      UIAL_M_OP_OR_VOF  = 4'hb,
      UIAL_M_CL_XOR_VON = 4'hc,
      UIAL_M_CL_XOR_VOF = 4'hd,
      UIAL_M_OP_XOR_VON = 4'he,
      UIAL_M_OP_XOR_VOF = 4'hf
   } uial_mode_t;

   typedef enum logic [1:0] {
      UIAL_F_DISABLED = 2'h0,
      UIAL_F_ALARM    = 2'h1,
      UIAL_F_CONTROL  = 2'h2
   } uial_func_t;

   typedef enum logic [1:0] {
      UIAL_S_IDLE   = 2'h0,
      UIAL_S_PICKUP = 2'h1,
      UIAL_S_ACTIVE = 2'h2
   } uial_state_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] label;
   } uial_msg_t;

   typedef struct packed {
      logic        valid;
      uial_func_t  func;
      logic [2:0]  relay;
   } uial_evt_t;
endpackage : uial_pkg
`default_nettype wire

// ==== rtl/uial_sync.sv ====
// three-stage synchroniser with agreement filter
`default_nettype none
module uial_sync (
   input  wire logic i_clock,
   input  wire logic i_rst,
   input  wire logic i_async,
   output logic      o_level
);
   logic s1;
   logic s2;
   logic s3;
   // s1 only feeds s2; a change counts when s2 and s3 agree
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         o_level <= 1'b0;
      end else begin
         s1 <= i_async;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            o_level <= s3;
         end
      end
   end
endmodule : uial_sync
`default_nettype wire

// ==== rtl/uial_top.sv ====
// user input assertion logic with apb setpoints and interrupt
// Functional notes
// - closed and virtual off asserts
// - open and virtual on asserts
// - open and virtual off asserts
// - closed or virtual on asserts
// - closed or virtual off asserts
// - open or virtual on asserts
// - open or virtual off asserts
// - closed xor virtual on asserts
// - message shows programmed or default label
// - alarm energises aux relay and LED
// - each assertion logs one recorder event
// - deassertion clears message, relay, LED
// - or modes hold outputs across handover
// - no message while condition false
// - relay selectable 3-7 after pickup delay
// - contact-only modes ignore virtual input
`default_nettype none
module uial_top (
   input  wire logic                 i_clock,
   input  wire logic                 i_rst,
   input  wire logic                 i_contact_closed,
   input  wire logic                 i_virtual_on,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   output uial_pkg::uial_msg_t       o_msg,
   output logic      [4:0]           o_aux_relay,
   output logic      [4:0]           o_aux_led,
   output uial_pkg::uial_evt_t       o_event,
   output logic                      o_irq
);
   import uial_pkg::*;

   logic        contact_s;
   logic        virtual_s;
   uial_mode_t  mode;
   uial_func_t  func;
   logic [2:0]  relay_sel;
   logic        label_set;
   logic [31:0] label;
   logic [15:0] delay;
   logic [1:0]  status;
   logic [1:0]  mask;
   logic [31:0] event_count;
   uial_state_t state;
   uial_state_t next_state;
   logic [20:0] unit_cnt;
   logic [15:0] tick_cnt;

   uial_sync u_sync_contact (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_async (i_contact_closed),
      .o_level (contact_s)
   );
   uial_sync u_sync_virtual (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_async (i_virtual_on),
      .o_level (virtual_s)
   );

   // combination of the two synchronised inputs
   logic cl;
   logic op;
   logic von;
   logic vof;
   logic cond;
   assign cl  = contact_s;
   assign op  = ~contact_s;
   assign von = virtual_s;
   assign vof = ~virtual_s;
   always_comb begin
      case (mode)
         UIAL_M_CLOSED:     cond = cl;
         UIAL_M_OPEN:       cond = op;
         UIAL_M_VON:        cond = von;
         UIAL_M_VOFF:       cond = vof;
         UIAL_M_CL_AND_VON: cond = cl & von;
         UIAL_M_CL_AND_VOF: cond = cl & vof;
         UIAL_M_OP_AND_VON: cond = op & von;
         UIAL_M_OP_AND_VOF: cond = op & vof;
         UIAL_M_CL_OR_VON:  cond = cl | von;
         UIAL_M_CL_OR_VOF:  cond = cl | vof;
         UIAL_M_OP_OR_VON:  cond = op | von;
         UIAL_M_OP_OR_VOF:  cond = op | vof;
         UIAL_M_CL_XOR_VON: cond = cl ^ von;
         UIAL_M_CL_XOR_VOF: cond = cl ^ vof;
         UIAL_M_OP_XOR_VON: cond = op ^ von;
         UIAL_M_OP_XOR_VOF: cond = op ^ vof;
         default:           cond = 1'b0;
      endcase
   end

   // pickup delay: delay units of 10 ms each
   logic unit_tick;
   logic delay_done;
   logic enabled;
   assign unit_tick  = (unit_cnt == 21'(UIAL_DLY_UNIT_CYC - 1));
   assign delay_done = (tick_cnt >= delay);
   assign enabled    = (func != UIAL_F_DISABLED);

   always_comb begin
      case (state)
         UIAL_S_IDLE:
            next_state = (cond && enabled) ? UIAL_S_PICKUP : UIAL_S_IDLE;
         UIAL_S_PICKUP:
            if (!cond || !enabled) begin
               next_state = UIAL_S_IDLE;
            end else if (delay_done) begin
               next_state = UIAL_S_ACTIVE;
            end else begin
               next_state = UIAL_S_PICKUP;
            end
         UIAL_S_ACTIVE:
            // or modes: cond stays high while term moves, no gap
            next_state = (cond && enabled) ? UIAL_S_ACTIVE
                                           : UIAL_S_IDLE;
         default:
            next_state = UIAL_S_IDLE;
      endcase
   end

   logic going_active;
   logic going_idle;
   assign going_active = (state != UIAL_S_ACTIVE) &&
                         (next_state == UIAL_S_ACTIVE);
   assign going_idle   = (state == UIAL_S_ACTIVE) &&
                         (next_state != UIAL_S_ACTIVE);

   // one delay unit is over a million cycles, so 21 bits
   always_ff @(posedge i_clock) begin
      if (i_rst || state != UIAL_S_PICKUP) begin
         unit_cnt <= 21'h00_0000;
         tick_cnt <= 16'h0000;
      end else if (unit_tick) begin
         unit_cnt <= 21'h00_0000;
         tick_cnt <= tick_cnt + 16'h0001;
      end else begin
         unit_cnt <= unit_cnt + 21'h00_0001;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state <= UIAL_S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // outputs
   logic        active;
   logic        show_msg;
   logic [4:0]  relay_onehot;
   logic [2:0]  relay_idx;
   assign active    = (next_state == UIAL_S_ACTIVE);
   assign show_msg  = active && (func == UIAL_F_ALARM);
   assign relay_idx = relay_sel - UIAL_RLY_MIN;
   assign relay_onehot = 5'(5'h01 << relay_idx);

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_msg       <= '0;
         o_aux_relay <= 5'h00;
         o_aux_led   <= 5'h00;
         o_event     <= '0;
      end else begin
         o_msg.valid <= show_msg;
         o_msg.label <= label_set ? label : UIAL_LABEL_DEFAULT;
         o_aux_relay <= active ? relay_onehot : 5'h00;
         o_aux_led   <= active ? relay_onehot : 5'h00;
         o_event.valid <= going_active;
         o_event.func  <= func;
         o_event.relay <= relay_sel;
      end
   end

   // apb slave, zero wait states
   logic wr_en;
   logic rd_en;
   logic hit;
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign hit     = (paddr == UIAL_OFS_CTRL)  || (paddr == UIAL_OFS_LABEL) ||
                    (paddr == UIAL_OFS_DELAY) || (paddr == UIAL_OFS_STATUS) ||
                    (paddr == UIAL_OFS_EVENT) || (paddr == UIAL_OFS_MASK);
   assign pslverr = psel && penable && !hit;

   logic [2:0] wr_rly;
   logic       rly_ok;
   logic [1:0] ev_set;
   logic       st_rd;
   assign wr_rly = pwdata[UIAL_CTRL_RLY_LSB +: 3];
   assign rly_ok = (wr_rly >= UIAL_RLY_MIN) && (wr_rly <= UIAL_RLY_MAX);
   assign ev_set = {going_idle, going_active};
   assign st_rd  = rd_en && (paddr == UIAL_OFS_STATUS);

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         mode      <= UIAL_M_CLOSED;
         func      <= UIAL_F_ALARM;
         relay_sel <= UIAL_RLY_MIN;
         label_set <= 1'b0;
         label     <= UIAL_LABEL_DEFAULT;
         delay     <= UIAL_DLY_RESET;
         mask      <= 2'h0;
      end else if (wr_en) begin
         if (paddr == UIAL_OFS_CTRL) begin
            mode      <= uial_mode_t'(pwdata[UIAL_CTRL_MODE_LSB +: 4]);
            func      <= uial_func_t'(pwdata[UIAL_CTRL_FUNC_LSB +: 2]);
            // out-of-range relay numbers keep the old choice
            relay_sel <= rly_ok ? wr_rly : relay_sel;
            label_set <= pwdata[UIAL_CTRL_LBL_BIT];
         end
         if (paddr == UIAL_OFS_LABEL) begin
            label <= pwdata;
         end
         if (paddr == UIAL_OFS_DELAY) begin
            delay <= pwdata[15:0];
         end
         if (paddr == UIAL_OFS_MASK) begin
            mask <= pwdata[1:0];
         end
      end
   end

   // sticky status, set wins over read-clear
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         status      <= 2'h0;
         event_count <= UIAL_ZERO;
      end else begin
         status <= (st_rd ? 2'h0 : status) | ev_set;
         if (going_active) begin
            event_count <= event_count + 32'h0000_0001;
         end
      end
   end

   assign o_irq = |(status & mask);

   logic [31:0] ctrl_rd;
   assign ctrl_rd = {19'h0, label_set, 1'b0, relay_sel, 2'h0, func, mode};
   always_comb begin
      case (paddr)
         UIAL_OFS_CTRL:   prdata = ctrl_rd;
         UIAL_OFS_LABEL:  prdata = label;
         UIAL_OFS_DELAY:  prdata = {16'h0, delay};
         UIAL_OFS_STATUS: prdata = {28'h0, contact_s, virtual_s, status};
         UIAL_OFS_EVENT:  prdata = event_count;
         UIAL_OFS_MASK:   prdata = {30'h0, mask};
         default:         prdata = UIAL_ZERO;
      endcase
   end

   // checks
   chk_and_mode_cond: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (mode == UIAL_M_CL_AND_VOF) |-> (cond == (contact_s & ~virtual_s)))
      else $error("closed and voff mismatch");
   chk_or_no_gap: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (state == UIAL_S_ACTIVE && (contact_s | virtual_s) && enabled
       && mode == UIAL_M_CL_OR_VON) |=> (state == UIAL_S_ACTIVE))
      else $error("or mode dropped");
   chk_msg_false: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (!cond) |=> !o_msg.valid)
      else $error("message while false");
   chk_event_once: assert property (
      @(posedge i_clock) disable iff (i_rst)
      o_event.valid |=> !o_event.valid)
      else $error("event longer than a pulse");
   chk_relay_range: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (relay_sel >= UIAL_RLY_MIN) && (relay_sel <= UIAL_RLY_MAX))
      else $error("relay out of range");
   chk_clear_outputs: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (state == UIAL_S_ACTIVE && !(cond && enabled))
      |=> (o_aux_relay == 5'h00 && o_aux_led == 5'h00 && !o_msg.valid))
      else $error("outputs held after clear");
   chk_active_relay: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (state == UIAL_S_ACTIVE) |-> ($onehot(o_aux_relay)
       && o_aux_led == o_aux_relay))
      else $error("relay or led not energised");
   chk_event_rise: assert property (
      @(posedge i_clock) disable iff (i_rst)
      going_active |=> (o_event.valid && state == UIAL_S_ACTIVE))
      else $error("assertion without event");
   chk_contact_only: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (mode == UIAL_M_CLOSED || mode == UIAL_M_OPEN)
      |-> (cond == (contact_s ^ (mode == UIAL_M_OPEN))))
      else $error("contact-only mode used virtual input");

   cov_assert: cover property (@(posedge i_clock) o_event.valid);
   cov_clear: cover property (@(posedge i_clock) going_idle);
   cov_irq: cover property (@(posedge i_clock) o_irq);
   cov_or_handover: cover property (@(posedge i_clock)
      (state == UIAL_S_ACTIVE) && $changed({contact_s, virtual_s}));
endmodule : uial_top
`default_nettype wire

// ==== verification/uial_field_model.sv ====
// field-side model: contact and virtual input sources
`default_nettype none
module uial_field_model (
   input  wire logic i_clock,
   input  wire logic i_cmd_closed,
   input  wire logic i_cmd_von,
   output logic      o_contact_closed,
   output logic      o_virtual_on
);
   timeunit 1ns;
   timeprecision 1ps;
   // levels move only just after an edge, never mid-cycle
   initial begin
      o_contact_closed = 1'b0;
      o_virtual_on     = 1'b0;
   end
   always @(posedge i_clock) begin
      o_contact_closed <= i_cmd_closed;
      o_virtual_on     <= i_cmd_von;
   end
endmodule : uial_field_model
`default_nettype wire

// ==== verification/uial_top_test.sv ====
// self-checking bench for the user input assertion logic
`default_nettype none
module uial_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import uial_pkg::*;
   logic        i_clock, i_rst, psel, penable, pwrite, pready, pslverr;
   logic        cmd_c, cmd_v, c_pin, v_pin, o_irq, err, prev_x;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, lbl;
   logic [4:0]  o_aux_relay, o_aux_led, ev_last;
   uial_msg_t   o_msg;
   uial_evt_t   o_event;
   int          errors, compares, ev_n, ev_x, cur_m, cur_f, cur_r, lbl_on;
   int          m, r;

   uial_top DUT (.i_clock, .i_rst, .i_contact_closed(c_pin),
      .i_virtual_on(v_pin), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .o_msg, .o_aux_relay, .o_aux_led,
      .o_event, .o_irq);
   uial_field_model FIELD (.i_clock, .i_cmd_closed(cmd_c),
      .i_cmd_von(cmd_v), .o_contact_closed(c_pin), .o_virtual_on(v_pin));

   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end
   initial ev_n = 0;
   always @(posedge i_clock) begin
      if (o_event.valid === 1'b1) begin
         ev_n    <= ev_n + 1;
         ev_last <= {o_event.func, o_event.relay};
      end
   end

   task end_sim;
      if (errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task chk_out(input logic [31:0] g, input logic [31:0] e, input string s);
      compares++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %0t output %s", $time, s);
      end
   endtask : chk_out
   task chk_reg(input logic [31:0] g, input logic [31:0] e, input string s);
      compares++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %0t register %s", $time, s);
      end
   endtask : chk_reg
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge i_clock);
   endtask : apb
   // reference combination, in two-input modes bit1 = open, bit0 = virtual off
   function automatic logic act(int md, logic c, logic v);
      logic a, b;
      a = md[1] ? !c : c;
      b = md[0] ? !v : v;
      case (md >> 2)
         0: act = (md < 2) ? (c ^ md[0]) : (v ^ md[0]);
         1: act = a && b;
         2: act = a || b;
         default: act = a ^ b;
      endcase
   endfunction : act
   task step(input logic c, input logic v);
      logic x;
      logic [4:0] er;
      cmd_c <= c; cmd_v <= v;
      // pin to output is about six cycles, so twelve is settled
      repeat (12) @(posedge i_clock);
      x = act(cur_m, c, v) && cur_f != 0;
      if (x && !prev_x) ev_x++;
      prev_x = x;
      er = x ? 5'h01 << (cur_r - 3) : 5'h00;
      chk_out(o_aux_relay, er, "relay");
      chk_out(o_aux_led, er, "led");
      chk_out(o_msg.valid, x && cur_f == 1, "msg");
      if (x && cur_f == 1)
         chk_out(o_msg.label, lbl_on ? lbl : UIAL_LABEL_DEFAULT, "lbl");
      chk_out(ev_n, ev_x, "event");
      if (x)
         chk_out(ev_last, 32'(cur_f << 3 | cur_r), "event tag");
   endtask : step
   // config changes only while idle, so no event hides in the switch
   task cfg(input int md, input int f, input int rl, input int l);
      apb(1'b1, UIAL_OFS_CTRL, 32'(md | f << 4 | rl << 8 | l << 12));
      cur_m = md; cur_f = f; lbl_on = l;
      if (rl >= 3 && rl <= 7) cur_r = rl;
      step(cmd_c, cmd_v);
   endtask : cfg
   task park;
      int k;
      for (k = 0; k < 4; k++) if (!act(cur_m, k[1], k[0])) break;
      step(k[1], cmd_v);
      step(k[1], k[0]);
   endtask : park

   initial begin
      i_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; cmd_c = 1'b0; cmd_v = 1'b0;
      errors = 0; compares = 0; ev_x = 0; prev_x = 1'b0; lbl = 32'h0;
      cur_m = 0; cur_f = 1; cur_r = 3; lbl_on = 0;
      void'($urandom(98));
      repeat (4) @(posedge i_clock);
      i_rst <= 1'b0;
      apb(1'b0, UIAL_OFS_CTRL, 32'h0);
      chk_reg(rd, 32'h0000_0310, "ctrl");
      chk_reg(err, 1'b0, "mapped ok");
      apb(1'b0, UIAL_OFS_DELAY, 32'h0);
      chk_reg(rd, 32'h0, "delay");
      apb(1'b1, UIAL_OFS_DELAY, 32'hbeef_0005);
      apb(1'b0, UIAL_OFS_DELAY, 32'h0);
      chk_reg(rd, 32'h5, "delay wr");
      apb(1'b1, UIAL_OFS_DELAY, 32'h0);
      step(1'b0, 1'b0);
      for (m = 0; m < 16; m++) begin
         cfg(m, 1, 3, 0);
         if ($urandom % 2) step(!cmd_c, cmd_v);
         step(cmd_c, !cmd_v);
         step(!cmd_c, cmd_v);
         step(cmd_c, !cmd_v);
         step(!cmd_c, cmd_v);
         park();
      end
      chk_out(o_irq, 32'h0, "irq masked");
      apb(1'b0, UIAL_OFS_EVENT, 32'h0);
      chk_reg(rd, 32'(ev_x), "event count");
      apb(1'b0, UIAL_OFS_STATUS, 32'h0);
      chk_reg(rd[1:0], 2'b11, "status");
      apb(1'b0, UIAL_OFS_STATUS, 32'h0);
      chk_reg(rd[1:0], 2'b00, "status clr");
      lbl = $urandom;
      apb(1'b1, UIAL_OFS_LABEL, lbl);
      apb(1'b0, UIAL_OFS_LABEL, 32'h0);
      chk_reg(rd, lbl, "label");
      for (r = 3; r <= 7; r++) begin
         cfg(0, 1, r, r % 2);
         step(1'b1, 1'b0);
         step(1'b0, 1'b0);
      end
      cfg(0, 1, 1, 0);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      cfg(0, 0, 3, 0);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      cfg(0, 2, 3, 0);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      cfg(0, 1, 3, 0);
      apb(1'b1, UIAL_OFS_MASK, 32'h1);
      apb(1'b0, UIAL_OFS_MASK, 32'h0);
      chk_reg(rd, 32'h1, "mask");
      apb(1'b0, UIAL_OFS_STATUS, 32'h0);
      chk_out(o_irq, 32'h0, "irq idle");
      step(1'b1, 1'b0);
      chk_out(o_irq, 32'h1, "irq set");
      apb(1'b0, UIAL_OFS_STATUS, 32'h0);
      chk_reg(rd[0], 1'b1, "status set");
      chk_reg(rd[3:2], 2'b10, "inputs seen");
      chk_out(o_irq, 32'h0, "irq clr");
      apb(1'b0, 8'h18, 32'h0);
      chk_reg({err, rd}, 33'h1_0000_0000, "unmapped rd");
      apb(1'b1, 8'h18, lbl);
      chk_reg(err, 1'b1, "unmapped wr");
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      chk_out(o_aux_relay, 32'h0, "relay reset");
      chk_out(o_msg.valid, 32'h0, "msg reset");
      apb(1'b0, UIAL_OFS_MASK, 32'h0);
      chk_reg(rd, 32'h0, "mask reset");
      prev_x = 1'b0;
      step(1'b1, 1'b0);
      end_sim();
   end
endmodule : uial_top_test
`default_nettype wire
